// [logic/tdm_frame_pkg.sv]
// Constants, codes and helpers for the framed line-port serial link.
// Assumes both ends import it whole and share one pclk.
package tdm_frame_pkg;
   // ----------------------------------------
   // Frame geometry
   // ----------------------------------------
   localparam int PORTS = 4;
   localparam int DATA_SLOTS = 8;
   localparam int SYNC_SLOT = 8;
   localparam int SYNC_BITS = 24;
   localparam int FRAME_BITS_2B1Q = 192;
   localparam int SLOT_BITS_2B1Q = 21;
   localparam int FRAME_BITS_4B3T = 128;
   localparam int SLOT_BITS_4B3T = 13;
   localparam int HEAD_BITS = 8;
   // Bit positions inside a data slot, first bit on the line is 0
   localparam int POS_CHG = 1;
   localparam int POS_PWR_DOWN = 2;
   localparam int POS_RANGE = 3;
   localparam int POS_LOOP = 4;
   localparam int POS_SYM = 5;
   // ----------------------------------------
   // Transmit latency
   // ----------------------------------------
   localparam int BIT_NS = 65;
   localparam int LAT_FIXED_BITS = 27;
   localparam int LAT_ANALOG_NS = 4000;
   localparam int LAT_ANALOG_BITS = (LAT_ANALOG_NS + BIT_NS - 1) / BIT_NS;
   localparam int LAT_MARGIN_BITS = 1;
   // ----------------------------------------
   // Pulse codes: bit 2 is the sign
   // ----------------------------------------
   localparam logic [2:0] SYM_ZERO = 3'h0;
   localparam logic [2:0] SYM_P1 = 3'h1;
   localparam logic [2:0] SYM_P3 = 3'h3;
   localparam logic [2:0] SYM_M1 = 3'h5;
   localparam logic [2:0] SYM_M3 = 3'h7;
   // ----------------------------------------
   // Companion register map and reset values
   // ----------------------------------------
   localparam logic [7:0] REG_PORT0 = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam int FLD_PWR_DOWN = 0;
   localparam int FLD_RANGE = 1;
   localparam int FLD_LOOP = 2;
   localparam int FLD_CHG = 3;
   localparam int FLD_SYM = 4;
   localparam logic [6:0] PORT_RESET = 7'h01;

   typedef enum logic [1:0] {HUNT = 2'b01, LOCKED = 2'b10} lock_state_t;

   function automatic logic [7:0] frame_len(input logic code_4b3t);
      frame_len = code_4b3t ? 8'(FRAME_BITS_4B3T) : 8'(FRAME_BITS_2B1Q);
   endfunction

   function automatic logic [4:0] slot_len(input logic code_4b3t);
      slot_len = code_4b3t ? 5'(SLOT_BITS_4B3T) : 5'(SLOT_BITS_2B1Q);
   endfunction
endpackage

// [logic/tdm_frame_if.sv]
// Wires between the front end and its companion transceiver.
// Assumes the bench instantiates it and hands a modport to each end.
interface tdm_frame_if;
   logic master_clock_out;
   logic serial_frame_in;
   logic serial_status_out;
   logic [3:0] adc_bitstream_outputs;

   modport device (
      output master_clock_out,
      output serial_status_out,
      output adc_bitstream_outputs,
      input serial_frame_in
   );
   modport companion (
      input master_clock_out,
      input serial_status_out,
      input adc_bitstream_outputs,
      output serial_frame_in
   );
endinterface

// [logic/slot_shifter.sv]
// Shift register for slot heads, MSB first on the line.
// Load takes priority over shift when both are raised.
module slot_shifter #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic shift_en,
   input wire logic load_en,
   input wire logic [W-1:0] load_word,
   input wire logic serial_in,
   // Result
   output logic [W-1:0] word,
   output logic serial_out
);
   initial begin
      if (W < 2) $error("slot_shifter needs W >= 2");
   end

   // Load or shift towards the MSB
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word <= '0;
      end else if (load_en) begin
         word <= load_word;
      end else if (shift_en) begin
         word <= {word[W-2:0], serial_in};
      end
   end

   assign serial_out = word[W-1];
endmodule

// [logic/line_front_end.sv]
// Front-end end of the link: makes the bit clock, locks to the frame,
// latches port settings, decodes pulses, returns level and ADC bits.
// Assumes the companion launches each bit after a rising bit clock edge.
//
// Chosen elsewhere: the address map (tdm_frame_pkg) and the APB slave port (line_transceiver_end).
module line_front_end
   import tdm_frame_pkg::*;
#(
   parameter int BIT_HALF = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link
   tdm_frame_if.device link,
   // Line code strap, 1 = 4B3T
   input wire logic line_code_4b3t,
   // Analog side inputs
   input wire logic [PORTS-1:0] level_above_threshold,
   input wire logic [PORTS-1:0] adc_modulator_bit,
   // Port controls and pulses
   output logic [PORTS-1:0] port_power_down,
   output logic [PORTS-1:0] port_range_on,
   output logic [PORTS-1:0] port_loop_closed,
   output logic [PORTS-1:0] line_pulse_strobe,
   output logic [3*PORTS-1:0] line_pulse_level,
   // Lock status
   output logic frame_locked
);
   initial begin
      if (BIT_HALF < 4) $error("BIT_HALF below 4 breaks bit sampling");
   end

   // ----------------------------------------
   // Bit clock divider
   // ----------------------------------------
   localparam logic [7:0] PHASE_LAST = 8'(2 * BIT_HALF - 1);
   logic [7:0] phase;
   logic bit_evt;
   logic mclk;

   // Free-running phase; sample point is the last phase of a bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= PHASE_LAST; // Bit end, so the first high half is full length
         mclk <= 1'b0;
      end else begin
         phase <= (phase == PHASE_LAST) ? 8'h00 : phase + 8'h01;
         mclk <= (phase == PHASE_LAST) || (phase < 8'(BIT_HALF - 1));
      end
   end

   assign bit_evt = (phase == PHASE_LAST);
   assign link.master_clock_out = mclk;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [1:0] rx_sync;
   logic [PORTS-1:0] lvl_s1, lvl_s2, adc_s1, adc_s2;
   logic rx_bit;

   // Two flops on the frame, level and ADC inputs; the line code strap is used directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sync <= '0;
         lvl_s1 <= '0;
         lvl_s2 <= '0;
         adc_s1 <= '0;
         adc_s2 <= '0;
      end else begin
         rx_sync <= {rx_sync[0], link.serial_frame_in};
         lvl_s1 <= level_above_threshold;
         lvl_s2 <= lvl_s1;
         adc_s1 <= adc_modulator_bit;
         adc_s2 <= adc_s1;
      end
   end

   assign rx_bit = rx_sync[1];

   // ----------------------------------------
   // Frame lock and position
   // ----------------------------------------
   lock_state_t state, next_state;
   logic [4:0] zero_run;
   logic [3:0] slot, next_slot;
   logic [4:0] off, next_off;
   logic [7:0] pos, next_pos;
   logic start_seen;
   logic [4:0] slen;
   logic [7:0] flen;

   assign slen = slot_len(line_code_4b3t);
   assign flen = frame_len(line_code_4b3t);
   assign start_seen = rx_bit && (zero_run >= 5'(SYNC_BITS));

   // Position of the bit sampled at this event
   always_comb begin
      next_state = state;
      next_slot = slot;
      next_off = off;
      next_pos = pos;
      if (start_seen) begin
         next_state = LOCKED;
         next_slot = '0;
         next_off = '0;
         next_pos = '0;
      end else if (state == LOCKED) begin
         next_pos = pos + 8'h01;
         if (slot == 4'(SYNC_SLOT)) begin
            next_off = off + 5'h01;
            if (off == 5'(SYNC_BITS - 1)) begin
               next_state = HUNT;
            end
         end else if (off == slen - 5'h01) begin
            next_slot = slot + 4'h1;
            next_off = '0;
            if (slot != 4'(DATA_SLOTS - 1) && !rx_bit) begin
               next_state = HUNT;
            end
         end else begin
            next_off = off + 5'h01;
         end
      end
   end

   // Zero run counter saturates at the sync length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_run <= '0;
      end else if (bit_evt) begin
         if (rx_bit) begin
            zero_run <= '0;
         end else if (zero_run < 5'(SYNC_BITS)) begin
            zero_run <= zero_run + 5'h01;
         end
      end
   end

   // Lock state and counters move once per bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= HUNT;
         slot <= '0;
         off <= '0;
         pos <= '0;
         frame_locked <= 1'b0;
      end else if (bit_evt) begin
         state <= next_state;
         slot <= next_slot;
         off <= next_off;
         pos <= next_pos;
         frame_locked <= (next_state == LOCKED);
      end
   end

   // ----------------------------------------
   // Slot head capture
   // ----------------------------------------
   logic [HEAD_BITS-1:0] head_word, head;
   logic head_done;
   logic [1:0] port;

   slot_shifter #(.W(HEAD_BITS)) rx_head (
      .pclk(pclk),
      .presetn(presetn),
      .shift_en(bit_evt),
      .load_en(1'b0),
      .load_word('0),
      .serial_in(rx_bit),
      .word(head_word),
      .serial_out()
   );

   assign head = {head_word[HEAD_BITS-2:0], rx_bit};
   assign port = next_slot[2:1];
   // Odd data slots only; even slots are reserved and ignored
   assign head_done = bit_evt && (next_state == LOCKED) && next_slot[0]
      && (next_slot < 4'(DATA_SLOTS)) && (next_off == 5'(HEAD_BITS - 1));

   // ----------------------------------------
   // Port controls and symbols
   // ----------------------------------------
   logic [2:0] sym [PORTS];
   logic [2:0] next_sym;
   logic s2, s1, s0;

   assign s2 = head[HEAD_BITS - 1 - POS_SYM];
   assign s1 = head[HEAD_BITS - 2 - POS_SYM];
   assign s0 = head[HEAD_BITS - 3 - POS_SYM];

   // Symbol decode for the active line code
   always_comb begin
      next_sym = SYM_ZERO;
      if (line_code_4b3t) begin
         case ({s2, s1})
            2'b10: next_sym = SYM_P1;
            2'b11: next_sym = SYM_M1;
            default: next_sym = SYM_ZERO;
         endcase
      end else if (!s2) begin
         case ({s1, s0})
            2'b00: next_sym = SYM_M3;
            2'b01: next_sym = SYM_M1;
            2'b10: next_sym = SYM_P3;
            default: next_sym = SYM_P1;
         endcase
      end
   end

   // Settings change only on a flagged head; reset powers down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_power_down <= '1;
         port_range_on <= '0;
         port_loop_closed <= '0;
      end else if (head_done && head[HEAD_BITS - 1 - POS_CHG]) begin
         port_power_down[port] <= head[HEAD_BITS - 1 - POS_PWR_DOWN];
         port_range_on[port] <= head[HEAD_BITS - 1 - POS_RANGE];
         port_loop_closed[port] <= head[HEAD_BITS - 1 - POS_LOOP];
      end
   end

   // Latest symbol per port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < PORTS; k++) begin
            sym[k] <= SYM_ZERO;
         end
      end else if (head_done) begin
         sym[port] <= next_sym;
      end
   end

   // ----------------------------------------
   // Pulse scheduler
   // ----------------------------------------
   // Port k fires at a fixed frame position, a quarter frame apart,
   // so its latency after slot 2k+1 grows by 6 bits from one port to the next.
   logic [8:0] fire_base;
   assign fire_base = 9'(2 * slen) + 9'(3 + LAT_FIXED_BITS + LAT_ANALOG_BITS
      + LAT_MARGIN_BITS);

   function automatic logic [7:0] fire_pos(input logic [8:0] base,
                                            input logic [7:0] fl,
                                            input logic [1:0] k);
      logic [9:0] p;
      p = 10'(base) + 10'(k) * 10'(fl[7:2]);
      // Base plus three quarters of a frame stays below two frames
      if (p >= 10'(fl)) begin
         p = p - 10'(fl);
      end
      if (p >= 10'(fl)) begin
         p = p - 10'(fl);
      end
      fire_pos = p[7:0];
   endfunction

   // One strobe per port per frame while powered up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_pulse_strobe <= '0;
         line_pulse_level <= '0;
      end else begin
         for (int k = 0; k < PORTS; k++) begin
            line_pulse_strobe[k] <= bit_evt && (next_state == LOCKED)
               && !port_power_down[k]
               && (next_pos == fire_pos(fire_base, flen, 2'(k)));
            if (bit_evt && next_pos == fire_pos(fire_base, flen, 2'(k))) begin
               line_pulse_level[3*k +: 3] <= sym[k];
            end
         end
      end
   end

   // ----------------------------------------
   // Level detect and status line
   // ----------------------------------------
   logic [PORTS-1:0] seen, lvl_bit;
   logic status_q;

   // One frame is one update interval; a new crossing wins over the restart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen <= '0;
         lvl_bit <= '0;
      end else if (bit_evt && start_seen) begin
         lvl_bit <= seen | lvl_s2;
         seen <= lvl_s2;
      end else begin
         seen <= seen | lvl_s2;
      end
   end

   // Level bit after the start bit of each served slot, else low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= 1'b0;
      end else if (bit_evt) begin
         status_q <= (next_state == LOCKED) && next_slot[0]
            && (next_slot < 4'(DATA_SLOTS)) && (next_off != 5'h00)
            && lvl_bit[port];
      end
   end

   assign link.serial_status_out = status_q;

   // ----------------------------------------
   // ADC bit streams
   // ----------------------------------------
   logic [PORTS-1:0] adc_q;

   // Each port on its own line, held low in power down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_q <= '0;
      end else begin
         adc_q <= adc_s2 & ~port_power_down;
      end
   end

   assign link.adc_bitstream_outputs = adc_q;
endmodule

// [logic/line_transceiver_end.sv]
// Companion end: builds frames from APB registers and reads back
// level bits and ADC streams. Assumes one bit per bit clock period.
module line_transceiver_end
   import tdm_frame_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link
   tdm_frame_if.companion link,
   // Line code strap, 1 = 4B3T
   input wire logic line_code_4b3t,
   // User side
   output logic [PORTS-1:0] adc_bits,
   output logic frame_start
);
   // ----------------------------------------
   // Synchronisers and edges
   // ----------------------------------------
   logic [2:0] ck;
   logic [1:0] st;
   logic [PORTS-1:0] a1, a2;
   logic rise, fall;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ck <= '0;
         st <= '0;
         a1 <= '0;
         a2 <= '0;
         adc_bits <= '0;
      end else begin
         ck <= {ck[1:0], link.master_clock_out};
         st <= {st[0], link.serial_status_out};
         a1 <= link.adc_bitstream_outputs;
         a2 <= a1;
         adc_bits <= a2;
      end
   end

   assign rise = ck[1] && !ck[2];
   assign fall = !ck[1] && ck[2];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [6:0] port_reg [PORTS];
   logic [PORTS-1:0] lvl_rx;
   logic wr, hit_port, hit_stat, sent;
   logic [1:0] sent_port;

   assign wr = psel && penable && pready && pwrite;
   assign hit_port = paddr[1:0] == 2'b00 && paddr < REG_STATUS;
   assign hit_stat = paddr == REG_STATUS;

   // Software write loads the change request from pwdata bit 3; sending a head clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < PORTS; k++) begin
            port_reg[k] <= PORT_RESET;
         end
      end else begin
         if (sent) begin
            port_reg[sent_port][FLD_CHG] <= 1'b0;
         end
         if (wr && hit_port) begin
            port_reg[paddr[3:2]] <= pwdata[6:0];
         end
      end
   end

   // One wait-free access phase; answer registered in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         if (psel && !penable) begin
            pslverr <= !(hit_port || hit_stat);
            prdata <= hit_port ? {25'h0, port_reg[paddr[3:2]]}
               : hit_stat ? {28'h0, lvl_rx} : 32'h0;
         end
      end
   end

   // ----------------------------------------
   // Frame generator
   // ----------------------------------------
   logic [3:0] slot;
   logic [4:0] off;
   logic [4:0] slen;
   logic new_slot, load;
   logic [3:0] nslot;
   logic [7:0] head;
   logic [6:0] r;

   assign slen = slot_len(line_code_4b3t);
   assign new_slot = (slot == 4'(SYNC_SLOT)) ? off == 5'(SYNC_BITS - 1)
      : off == slen - 5'h01;
   assign nslot = (slot == 4'(SYNC_SLOT)) ? 4'h0 : slot + 4'h1;
   assign r = port_reg[nslot[2:1]];
   assign load = rise && new_slot;
   assign sent = load && nslot[0] && nslot < 4'(DATA_SLOTS);
   assign sent_port = nslot[2:1];

   // Head word for the slot that starts; controls zero unless flagged
   always_comb begin
      head = 8'h00;
      if (nslot < 4'(DATA_SLOTS)) begin
         head = 8'h80;
         if (nslot[0]) begin
            head[6] = r[FLD_CHG];
            head[5] = r[FLD_CHG] & r[FLD_PWR_DOWN];
            head[4] = r[FLD_CHG] & r[FLD_RANGE];
            head[3] = r[FLD_CHG] & r[FLD_LOOP];
            head[2:0] = line_code_4b3t ? {r[5:4], 1'b0} : r[6:4];
         end
      end
   end

   slot_shifter #(.W(HEAD_BITS)) tx_head (
      .pclk(pclk),
      .presetn(presetn),
      .shift_en(rise),
      .load_en(load),
      .load_word(head),
      .serial_in(1'b0),
      .word(),
      .serial_out(link.serial_frame_in)
   );

   // Starts in the sync slot so the first frame is clean
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot <= 4'(SYNC_SLOT);
         off <= 5'(SYNC_BITS - 1);
         frame_start <= 1'b0;
      end else begin
         frame_start <= load && nslot == 4'h0;
         if (rise) begin
            slot <= new_slot ? nslot : slot;
            off <= new_slot ? 5'h00 : off + 5'h01;
         end
      end
   end

   // Level bit taken mid-slot of each served slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_rx <= '0;
      end else if (fall && slot[0] && slot < 4'(DATA_SLOTS)
                   && off == {1'b0, slen[4:1]}) begin
         lvl_rx[slot[2:1]] <= st[1];
      end
   end
endmodule

// [test/tdm_link_assertions.sv]
// Checker for the wires between the two link ends.
// Assumes BIT_HALF of 4 and the bench wiring the interface signals in.
module tdm_link_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link wires
   input wire logic master_clock_out,
   input wire logic serial_frame_in,
   input wire logic serial_status_out,
   input wire logic [3:0] adc_bitstream_outputs
);
   logic [11:0] zrun;
   logic [11:0] fcnt;
   logic sfi_d;
   logic sync_end;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------
   // Helpers
   // ---------
   // First one after a long zero run starts slot zero
   assign sync_end = serial_frame_in && !sfi_d && zrun >= 12'h0BE;
   // Zero run length and cycles since the last slot zero start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zrun <= 12'h000;
         fcnt <= 12'h000;
         sfi_d <= 1'b0;
      end else begin
         sfi_d <= serial_frame_in;
         zrun <= serial_frame_in ? 12'h000 : zrun + 12'h001;
         fcnt <= sync_end ? 12'h001 : (fcnt == 12'h000 ? 12'h000 : fcnt + 12'h001);
      end
   end
   // ---------
   // Checks
   // ---------
   chk_clock_high_half:
      assert property ($rose(master_clock_out) |-> master_clock_out[*4] ##1 !master_clock_out)
      else $error("bit clock high half wrong");
   chk_clock_low_half:
      assert property ($fell(master_clock_out) |-> !master_clock_out[*4] ##1 master_clock_out)
      else $error("bit clock low half wrong");
   chk_frame_launch:
      assert property ($changed(serial_frame_in) |-> $past(master_clock_out))
      else $error("frame line moved outside high half");
   chk_zero_run_bound:
      assert property (zrun <= 12'h168)
      else $error("zero run too long");
   chk_frame_period:
      assert property (sync_end && fcnt != 12'h000 |-> fcnt == 12'h600 || fcnt == 12'h400)
      else $error("frame length wrong");
   chk_status_sync_low:
      assert property (zrun > 12'h0E0 |-> !serial_status_out)
      else $error("status high during sync");
   chk_status_reset_low:
      assert property ($rose(presetn) |-> !serial_status_out [*8])
      else $error("status high after reset");
   chk_adc_reset_low:
      assert property ($rose(presetn) |-> (adc_bitstream_outputs == 4'h0) [*8])
      else $error("adc stream active after reset");
   // Main scenarios
   cover property (sync_end);
   cover property (serial_status_out);
   cover property (adc_bitstream_outputs == 4'hF);
endmodule

// [test/line_port_tdm_frame_interface_bench.sv]
// Bench joining both link ends through the frame interface.
// Assumes BIT_HALF of 4 and APB access to the companion registers.
module line_port_tdm_frame_interface_bench
   import tdm_frame_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, code;
   logic frame_locked, frame_start;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] lvl, adc, pdn, rng, lp, strobe, adc_bits;
   logic [11:0] plev;
   int fails, total_checks;
   tdm_frame_if link();
   // ---------
   // Ends and checker
   // ---------
   line_front_end line_front_end_inst (.pclk, .presetn, .link(link.device),
      .line_code_4b3t(code), .level_above_threshold(lvl), .adc_modulator_bit(adc),
      .port_power_down(pdn), .port_range_on(rng), .port_loop_closed(lp),
      .line_pulse_strobe(strobe), .line_pulse_level(plev), .frame_locked);
   line_transceiver_end line_transceiver_end_inst (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link.companion),
      .line_code_4b3t(code), .adc_bits, .frame_start);
   tdm_link_checker tdm_link_checker_inst (.pclk, .presetn,
      .master_clock_out(link.master_clock_out), .serial_frame_in(link.serial_frame_in),
      .serial_status_out(link.serial_status_out),
      .adc_bitstream_outputs(link.adc_bitstream_outputs));
   // 10 MHz clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // ---------
   // Tasks
   // ---------
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results;
      if (fails == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Waits for a strobe bit, or frame start when k is 4
   task automatic wait_sig(input int k, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((k < 4 ? strobe[k] : frame_start) !== 1'b1 && n < 2000);
      if (n == 2000) begin
         fails++;
         results();
      end
   endtask
   task automatic frames(input int f);
      int n;
      repeat (f) wait_sig(4, n);
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fails++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Full pass through one line code
   task automatic run_mode(input logic c, input logic [11:0] sym, input logic [11:0] lev);
      int n;
      int lat;
      @(posedge pclk);
      presetn <= 1'b0;
      code <= c;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("reset ports", 32'({pdn, rng, lp}), 32'hF00);
      apb(1'b0, 8'h00, 32'h0);
      check("port reset", rd, 32'h1);
      frames(3);
      check("locked", 32'(frame_locked), 32'h1);
      for (int k = 0; k < 4; k++)
         apb(1'b1, 8'(4 * k), {25'h0, sym[3*k+:3], 1'b1, k[1], k[0], 1'b0});
      frames(2);
      check("controls", 32'({pdn, rng, lp}), 32'h0AC);
      check("levels", 32'(plev), 32'(lev));
      apb(1'b0, 8'h00, 32'h0);
      check("change clear", rd, {25'h0, sym[2:0], 4'h0});
      for (int k = 0; k < 4; k++)
         apb(1'b1, 8'(4 * k), {25'h0, sym[3*k+:3], 1'b0, ~k[1], ~k[0], 1'b1});
      lvl <= 4'h5;
      adc <= 4'hF;
      frames(3);
      check("held", 32'({pdn, rng, lp}), 32'h0AC);
      apb(1'b0, 8'h10, 32'h0);
      check("level bits", rd, 32'h5);
      check("adc", 32'(adc_bits), 32'hF);
      // Port 0 pulse: slot 1 end plus 3, fixed, analog and margin bits, 5 cycles of sync
      lat = 8 * (2 * (c ? SLOT_BITS_4B3T : SLOT_BITS_2B1Q) + 3 + LAT_FIXED_BITS
         + LAT_ANALOG_BITS + LAT_MARGIN_BITS) + 5;
      wait_sig(4, n);
      wait_sig(0, n);
      check("latency", 32'(n), 32'(lat));
      for (int k = 0; k < 3; k++) begin
         wait_sig(k, n);
         wait_sig(k + 1, n);
         check("spacing", 32'(n), c ? 32'h100 : 32'h180);
      end
      lvl <= 4'h0;
      apb(1'b1, 8'h0C, {25'h0, 3'b101, 4'b1001});
      frames(3);
      check("port3 down", 32'({pdn, adc_bits}), 32'h87);
      check("adc wires", 32'(link.adc_bitstream_outputs), 32'h7);
      check("zero sym", 32'(plev), 32'(lev & 12'h1FF));
      apb(1'b0, 8'h10, 32'h0);
      check("level clear", rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped", 32'({err, rd[3:0]}), 32'h10);
   endtask
   // Main sequence: both line codes
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      code = 1'b0;
      lvl = 4'h0;
      adc = 4'h0;
      fails = 0;
      total_checks = 0;
      run_mode(1'b0, 12'h688, 12'h2EF);
      run_mode(1'b1, 12'h2D0, 12'h148);
      results();
   end
endmodule
